// ---- verilog/flash_program_erase_control.sv ----
// flash program/erase/verify sequencing driven by cpu software
// assumes the cpu runs the update routine from ram; flash cells sit outside
`timescale 1ns/1ps
module flash_program_erase_control
    import flash_ctl_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // register port
    input  wire logic [15:0]       reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    // cpu flash access
    input  wire logic [ADDR_W-1:0] flash_addr,
    input  wire logic [7:0]        flash_wdata,
    input  wire logic              flash_wr,
    input  wire logic              flash_rd,
    // flash array side
    output logic [ADDR_W-1:0]      cell_addr,
    output logic [7:0]             cell_data,
    output logic                   cell_program,
    output logic                   cell_erase,
    output logic                   cell_pverify,
    output logic                   cell_everify,
    output logic [15:0]            cell_block_sel,
    output logic                   read_blocked,
    output logic [2:0]             mode
);
    logic [7:0]        mode_control;
    logic [7:0]        block_sel_1;
    logic [7:0]        block_sel_2;
    logic [ADDR_W-1:0] addr_latch;
    logic [7:0]        data_latch;
    flash_mode_e       next_mode;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
        hit = (a == r);
    endfunction : hit

    // registers; reserved mode bits read as zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_control <= REG_RESET;
            block_sel_1  <= REG_RESET;
            block_sel_2  <= REG_RESET;
        end else if (reg_wr) begin
            if (hit(reg_addr, FLASH_MODE_CONTROL_ADDR))
                mode_control <= reg_wdata & MODE_CONTROL_MASK;
            if (hit(reg_addr, ERASE_BLOCK_SELECT_1_ADDR))
                block_sel_1 <= reg_wdata;
            if (hit(reg_addr, ERASE_BLOCK_SELECT_2_ADDR))
                block_sel_2 <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (hit(reg_addr, FLASH_MODE_CONTROL_ADDR))
                reg_rdata <= mode_control;
            else if (hit(reg_addr, ERASE_BLOCK_SELECT_1_ADDR))
                reg_rdata <= block_sel_1;
            else if (hit(reg_addr, ERASE_BLOCK_SELECT_2_ADDR))
                reg_rdata <= block_sel_2;
            else
                reg_rdata <= 8'h00;
        end
    end

    // mode decode; program/erase win over verify so cells never see both
    always_comb begin
        next_mode = MODE_IDLE;
        if (mode_control[PROGRAM_BIT_POS])
            next_mode = MODE_PROGRAM;
        else if (mode_control[ERASE_BIT_POS])
            next_mode = MODE_ERASE;
        else if (mode_control[PROGRAM_VERIFY_BIT_POS])
            next_mode = MODE_PVERIFY;
        else if (mode_control[ERASE_VERIFY_BIT_POS])
            // a zero dummy write under erase-verify is a prewrite check
            next_mode = (data_latch == PREWRITE_VALUE) ? MODE_PWVERIFY
                                                       : MODE_EVERIFY;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            mode <= MODE_IDLE;
        else
            mode <= next_mode;
    end

    // latches; a write during a pulse is ignored so the pulse target holds
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_latch <= '0;
            data_latch <= 8'h00;
        end else if (flash_wr && !mode_control[PROGRAM_BIT_POS]
                     && !mode_control[ERASE_BIT_POS]) begin
            addr_latch <= flash_addr;
            data_latch <= flash_wdata;
        end
    end

    // cell strobes follow the priority decode with one register stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cell_program   <= 1'b0;
            cell_erase     <= 1'b0;
            cell_pverify   <= 1'b0;
            cell_everify   <= 1'b0;
            cell_addr      <= '0;
            cell_data      <= 8'h00;
            cell_block_sel <= 16'h0000;
        end else begin
            cell_program <= (next_mode == MODE_PROGRAM)
                            && ({{(32-ADDR_W){1'b0}}, addr_latch}
                                <= 32'(FLASH_ADDR_LAST));
            cell_erase   <= (next_mode == MODE_ERASE);
            cell_pverify <= (next_mode == MODE_PVERIFY);
            cell_everify <= (next_mode == MODE_EVERIFY)
                            || (next_mode == MODE_PWVERIFY);
            cell_addr      <= addr_latch;
            cell_data      <= data_latch;
            cell_block_sel <= {block_sel_2, block_sel_1};
        end
    end

    // flash reads during a pulse would return garbage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            read_blocked <= 1'b0;
        else
            read_blocked <= flash_rd && (mode_control[PROGRAM_BIT_POS]
                                       || mode_control[ERASE_BIT_POS]);
    end

    a_program_follows_bit: assert property (
        @(posedge clk) disable iff (!rst_n)
        (mode_control[PROGRAM_BIT_POS]
         && addr_latch <= FLASH_ADDR_LAST[ADDR_W-1:0])
        |=> cell_program)
        else $error("program strobe missing while bit set");
    a_program_stops: assert property (
        @(posedge clk) disable iff (!rst_n)
        !mode_control[PROGRAM_BIT_POS] |=> !cell_program)
        else $error("program strobe outlived bit");
    a_erase_follows_bit: assert property (
        @(posedge clk) disable iff (!rst_n)
        mode_control[ERASE_BIT_POS] == $past(mode_control[ERASE_BIT_POS])
        |-> cell_erase == $past(mode_control[ERASE_BIT_POS]
                                 && !mode_control[PROGRAM_BIT_POS]))
        else $error("erase strobe does not track bit");
    a_latch_capture: assert property (
        @(posedge clk) disable iff (!rst_n)
        (flash_wr && mode_control[1:0] == 2'b00)
        |=> addr_latch == $past(flash_addr)
            && data_latch == $past(flash_wdata))
        else $error("flash write not latched");
    a_latch_hold_pulse: assert property (
        @(posedge clk) disable iff (!rst_n)
        (mode_control[1:0] != 2'b00) |=> $stable(data_latch))
        else $error("latch changed during pulse");
    a_verify_address: assert property (
        @(posedge clk) disable iff (!rst_n)
        cell_pverify |-> cell_addr == $past(addr_latch))
        else $error("verify not on latched address");
    a_read_blocked: assert property (
        @(posedge clk) disable iff (!rst_n)
        (flash_rd && mode_control[PROGRAM_BIT_POS]) |=> read_blocked)
        else $error("read during program not flagged");
    a_mode_exclusive: assert property (
        @(posedge clk) disable iff (!rst_n)
        !(cell_program && (cell_erase || cell_pverify || cell_everify)))
        else $error("program combined with another mode");
    a_range_guard: assert property (
        @(posedge clk) disable iff (!rst_n)
        cell_program |-> $past(addr_latch) <= FLASH_ADDR_LAST[ADDR_W-1:0])
        else $error("program outside valid range");

    // program cleared and program-verify set: the verify step of a retry
    sequence s_pv_only;
        !mode_control[PROGRAM_BIT_POS] && !mode_control[ERASE_BIT_POS]
        && mode_control[PROGRAM_VERIFY_BIT_POS];
    endsequence
    // erase-verify alone; a zero latch marks the prewrite check
    sequence s_ev_only;
        mode_control[ERASE_VERIFY_BIT_POS]
        && !mode_control[PROGRAM_BIT_POS] && !mode_control[ERASE_BIT_POS]
        && !mode_control[PROGRAM_VERIFY_BIT_POS];
    endsequence

    a_erase_stops: assert property (
        @(posedge clk) disable iff (!rst_n)
        !mode_control[ERASE_BIT_POS] |=> !cell_erase)
        else $error("erase strobe outlived bit");
    a_pverify_select: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_pv_only |=> cell_pverify && mode == MODE_PVERIFY)
        else $error("program-verify not selected");
    a_everify_select: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_ev_only |=> cell_everify && !cell_pverify)
        else $error("erase-verify not selected");
    a_prewrite_kind: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_ev_only ##0 (data_latch == PREWRITE_VALUE)
        |=> mode == MODE_PWVERIFY)
        else $error("prewrite-verify not reported");
    a_block_sel_track: assert property (
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> cell_block_sel == $past({block_sel_2, block_sel_1}))
        else $error("block select not passed to array");
    a_write_no_strobe: assert property (
        @(posedge clk) disable iff (!rst_n)
        (flash_wr && mode_control[1:0] == 2'b00)
        |=> !cell_program && !cell_erase)
        else $error("plain flash write reached the cells");
endmodule : flash_program_erase_control

// ---- verilog/flash_ctl_pkg.sv ----
// constants for the flash program/erase control block
// assumes a byte-wide register port addressed by full 16-bit cpu address
package flash_ctl_pkg;
    localparam logic [15:0] FLASH_MODE_CONTROL_ADDR = 16'hFF80;
    localparam logic [15:0] ERASE_BLOCK_SELECT_1_ADDR = 16'hFF82;
    localparam logic [15:0] ERASE_BLOCK_SELECT_2_ADDR = 16'hFF83;
    localparam logic [15:0] FLASH_ADDR_LAST = 16'h7FFF;
    // mode control bit positions
    localparam int PROGRAM_BIT_POS = 0;
    localparam int ERASE_BIT_POS = 1;
    localparam int PROGRAM_VERIFY_BIT_POS = 2;
    localparam int ERASE_VERIFY_BIT_POS = 3;
    localparam logic [7:0] MODE_CONTROL_MASK = 8'h0F;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] PREWRITE_VALUE = 8'h00;
    localparam logic [7:0] ERASED_VALUE = 8'hFF;

    typedef enum logic [2:0] {
        MODE_IDLE     = 3'b000,
        MODE_PROGRAM  = 3'b001,
        MODE_ERASE    = 3'b010,
        MODE_PVERIFY  = 3'b011,
        MODE_EVERIFY  = 3'b100,
        MODE_PWVERIFY = 3'b101
    } flash_mode_e;
endpackage : flash_ctl_pkg

// ---- test/test_flash_program_erase_control.sv ----
// self-checking bench for the flash program/erase control block
// assumes the design package is compiled first; no partner, bench drives ports
`timescale 1ns/1ps
module test_flash_program_erase_control;
    import flash_ctl_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic [15:0] flash_addr = 16'h0000;
    logic [7:0]  flash_wdata = 8'h00;
    logic        flash_wr = 1'b0;
    logic        flash_rd = 1'b0;
    logic [15:0] cell_addr;
    logic [7:0]  cell_data;
    logic        cell_program;
    logic        cell_erase;
    logic        cell_pverify;
    logic        cell_everify;
    logic [15:0] cell_block_sel;
    logic        read_blocked;
    logic [2:0]  mode;
    // bench copy of the expected state
    logic [7:0]  mc = 8'h00, e1 = 8'h00, e2 = 8'h00, ld = 8'h00, rdat = 8'h00;
    logic [15:0] la = 16'h0000;
    logic        blk = 1'b0;
    logic        probe = 1'b0;
    logic [55:0] notes[$];
    logic [55:0] exp_v, seen_v;
    logic [31:0] r;
    int          seed = 32'h265CA93E;
    int          num_errors = 0;
    int          checks_done = 0;
    int          tries;
    // 125 MHz: 10 us program pulse, 4 us verify settle
    localparam int PROG_PULSE_CYCLES = 1250;
    localparam int VERIFY_WAIT_CYCLES = 500;
    // erase pulse far shorter than software would use; the block does not
    // time it, and a real one would swamp the run
    localparam int ERASE_PULSE_CYCLES = 1000;
    localparam int MAX_ATTEMPTS = 50;
    localparam logic [15:0] WATCHDOG_CONTROL_STATUS_ADDR = 16'hFFA8;
    localparam logic [15:0] WATCHDOG_START = 16'hA578;
    localparam logic [15:0] WATCHDOG_STOP = 16'hA500;

    flash_program_erase_control flash_program_erase_control_i (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .flash_addr(flash_addr), .flash_wdata(flash_wdata),
        .flash_wr(flash_wr), .flash_rd(flash_rd), .cell_addr(cell_addr),
        .cell_data(cell_data), .cell_program(cell_program),
        .cell_erase(cell_erase), .cell_pverify(cell_pverify),
        .cell_everify(cell_everify), .cell_block_sel(cell_block_sel),
        .read_blocked(read_blocked), .mode(mode));

    always #4 clk = ~clk;

    function automatic logic [55:0] expect_now();
        logic [2:0] md;
        md = MODE_IDLE;
        if (mc[ERASE_VERIFY_BIT_POS]) md = (ld == PREWRITE_VALUE) ?
            MODE_PWVERIFY : MODE_EVERIFY;
        if (mc[PROGRAM_VERIFY_BIT_POS]) md = MODE_PVERIFY;
        if (mc[ERASE_BIT_POS]) md = MODE_ERASE;
        if (mc[PROGRAM_BIT_POS]) md = MODE_PROGRAM;
        // strobes follow the priority decode, not the raw bits
        return {rdat, la, ld,
                (md == MODE_PROGRAM) && (la <= FLASH_ADDR_LAST),
                md == MODE_ERASE, md == MODE_PVERIFY,
                (md == MODE_EVERIFY) || (md == MODE_PWVERIFY),
                e2, e1, blk, md};
    endfunction : expect_now

    task tally_and_finish;
        if (num_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    task check(input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    // kind: 0 reg write, 1 reg read, 2 flash write, 3 flash read
    task op(input int kind, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        flash_addr <= a;
        flash_wdata <= d;
        reg_wr <= (kind == 0);
        reg_rd <= (kind == 1);
        flash_wr <= (kind == 2);
        flash_rd <= (kind == 3);
        @(posedge clk);
        {reg_wr, reg_rd, flash_wr, flash_rd} <= 4'h0;
        blk = (kind == 3) && (mc[PROGRAM_BIT_POS] | mc[ERASE_BIT_POS]);
        if (kind == 0 && a == FLASH_MODE_CONTROL_ADDR)
            mc = d & MODE_CONTROL_MASK;
        if (kind == 0 && a == ERASE_BLOCK_SELECT_1_ADDR) e1 = d;
        if (kind == 0 && a == ERASE_BLOCK_SELECT_2_ADDR) e2 = d;
        if (kind == 1) rdat = (a == FLASH_MODE_CONTROL_ADDR) ? mc :
            (a == ERASE_BLOCK_SELECT_1_ADDR) ? e1 :
            (a == ERASE_BLOCK_SELECT_2_ADDR) ? e2 : 8'h00;
        // latches frozen while a pulse is running
        if (kind == 2 && !(mc[PROGRAM_BIT_POS] | mc[ERASE_BIT_POS])) begin
            la = a;
            ld = d;
        end
        // strobes land one edge after the register
        if (kind == 0 || kind == 2) @(posedge clk);
        notes.push_back(expect_now());
        probe <= 1'b1;
        @(posedge clk);
        probe <= 1'b0;
        blk = 1'b0;
    endtask : op

    // the watchdog lives elsewhere; its writes must fall through unmapped
    task watchdog_code(input logic [15:0] code);
        op(0, WATCHDOG_CONTROL_STATUS_ADDR, code[15:8]);
        op(0, WATCHDOG_CONTROL_STATUS_ADDR + 16'h0001, code[7:0]);
        op(1, WATCHDOG_CONTROL_STATUS_ADDR, 8'h00);
    endtask : watchdog_code

    task program_byte(input logic [15:0] a, input logic [7:0] d,
                      input int attempts);
        op(0, ERASE_BLOCK_SELECT_1_ADDR, 8'h01);
        op(0, ERASE_BLOCK_SELECT_2_ADDR, 8'h00);
        op(2, a, d);
        for (int n = 0; n < attempts && n < MAX_ATTEMPTS; n++) begin
            watchdog_code(WATCHDOG_START);
            op(0, FLASH_MODE_CONTROL_ADDR, 8'(1 << PROGRAM_BIT_POS));
            repeat (PROG_PULSE_CYCLES) @(posedge clk);
            op(3, a, 8'h00);
            op(0, FLASH_MODE_CONTROL_ADDR, 8'h00);
            watchdog_code(WATCHDOG_STOP);
            op(0, FLASH_MODE_CONTROL_ADDR, 8'(1 << PROGRAM_VERIFY_BIT_POS));
            repeat (VERIFY_WAIT_CYCLES) @(posedge clk);
            op(3, a, 8'h00);
            op(0, FLASH_MODE_CONTROL_ADDR, 8'h00);
        end
        op(0, ERASE_BLOCK_SELECT_1_ADDR, 8'h00);
    endtask : program_byte

    task erase_block(input logic [15:0] a);
        program_byte(a, PREWRITE_VALUE, 1);
        op(0, ERASE_BLOCK_SELECT_1_ADDR, 8'h01);
        watchdog_code(WATCHDOG_START);
        op(0, FLASH_MODE_CONTROL_ADDR, 8'(1 << ERASE_BIT_POS));
        repeat (ERASE_PULSE_CYCLES) @(posedge clk);
        // latch stays frozen while erasing
        op(2, a, ERASED_VALUE);
        op(0, FLASH_MODE_CONTROL_ADDR, 8'h00);
        watchdog_code(WATCHDOG_STOP);
        op(0, FLASH_MODE_CONTROL_ADDR, 8'(1 << ERASE_VERIFY_BIT_POS));
        repeat (VERIFY_WAIT_CYCLES) @(posedge clk);
        op(2, a, ERASED_VALUE);
        op(3, a, 8'h00);
        op(0, FLASH_MODE_CONTROL_ADDR, 8'h00);
        op(0, ERASE_BLOCK_SELECT_1_ADDR, 8'h00);
    endtask : erase_block

    always @(negedge clk) begin
        if (probe) begin
            exp_v = notes.pop_front();
            seen_v = {reg_rdata, cell_addr, cell_data, cell_program, cell_erase,
                      cell_pverify, cell_everify, cell_block_sel, read_blocked,
                      mode};
            check(24'(seen_v[55:48]), 24'(exp_v[55:48]));
            check(seen_v[47:24], exp_v[47:24]);
            check(24'(seen_v[23:20]), 24'(exp_v[23:20]));
            check(24'(seen_v[19:4]), 24'(exp_v[19:4]));
            check(24'(seen_v[3]), 24'(exp_v[3]));
            check(24'(seen_v[2:0]), 24'(exp_v[2:0]));
        end
    end

    initial begin
        #150000;
        num_errors++;
        tally_and_finish;
    end

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 5; a++) op(1, 16'hFF80 + 16'(a), 8'h00);
        for (int j = 0; j < 2; j++) begin
            for (int i = 0; i < 5; i++) begin
                r = $random(seed);
                op(0, ERASE_BLOCK_SELECT_1_ADDR, r[7:0]);
                op(0, ERASE_BLOCK_SELECT_2_ADDR, r[15:8]);
                op(1, ERASE_BLOCK_SELECT_1_ADDR, 8'h00);
                op(1, ERASE_BLOCK_SELECT_2_ADDR, 8'h00);
                r = $random(seed);
                // a zero byte lets erase-verify report prewrite-verify
                op(2, r[15:0], (j == 0) ? PREWRITE_VALUE : r[23:16]);
                // last pass mixes bits to exercise the decode priority
                op(0, FLASH_MODE_CONTROL_ADDR,
                   {r[31:28], (i < 4) ? 4'(1 << i) : r[3:0]});
                op(3, 16'h0000, 8'h00);
                op(1, FLASH_MODE_CONTROL_ADDR, 8'h00);
                r = $random(seed);
                op(2, r[15:0], r[23:16]);
                op(3, 16'h0000, 8'h00);
                op(0, FLASH_MODE_CONTROL_ADDR, 8'h00);
            end
        end
        r = $random(seed);
        tries = 1 + int'(r[25:24] % 3);
        program_byte({1'b0, r[14:0]}, r[23:16], tries);
        r = $random(seed);
        erase_block({1'b0, r[14:0]});
        tally_and_finish;
    end
endmodule : test_flash_program_erase_control
